//--- rtl/sppc_top.sv
`timescale 1ns/1ps
`include "sppc_consts.svh"

//Operation
// (RL1) receive clock pin is input by default, output when rx clock mode bit set.
// (RL2) transmit clock pin is input when tx clock mode bit is 0, else drives.
// (RL3) transmit clock pin level readable through sampled status bit in control register.
// (RL4) tx gpio enable turns the transmit clock pin into general-purpose I/O.
// (RL5) rx gpio enable turns the receive data pin into general-purpose I/O.
// (RL6) tx gpio enable turns the transmit data pin into general-purpose I/O.
// (RL7) receive frame sync pulse starts a receive frame; the source supplies it. Here pin control bit 2 also lets the port drive it.
// (RL8) rx gpio enable turns the receive frame sync pin into general-purpose I/O.
// (RL9) transmit frame sync pulse starts a transmit frame, from port or peer.
// (RL10) serial port reset returns an output transmit frame sync pin to input.
// (RL11) tx gpio enable turns the transmit frame sync pin into general-purpose I/O.
// (RL12) emulation off pin low floats every output-capable serial pin.
// (RL13) receive clock shifts receive data in; rx gpio enable makes it general I/O.
// (RL14) gpio pins take direction and value from per-pin bits; levels are readable.
module sppc_top (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata_q,
    input  wire logic        emulation_off_pin,
    input  wire logic        rx_clock_pin_i,
    output logic             rx_clock_pin_o,
    output logic             rx_clock_pin_oe,
    input  wire logic        tx_clock_pin_i,
    output logic             tx_clock_pin_o,
    output logic             tx_clock_pin_oe,
    input  wire logic        rx_data_pin_i,
    output logic             rx_data_pin_o,
    output logic             rx_data_pin_oe,
    input  wire logic        tx_data_pin_i,
    output logic             tx_data_pin_o,
    output logic             tx_data_pin_oe,
    input  wire logic        rx_frame_sync_pin_i,
    output logic             rx_frame_sync_pin_o,
    output logic             rx_frame_sync_pin_oe,
    input  wire logic        tx_frame_sync_pin_i,
    output logic             tx_frame_sync_pin_o,
    output logic             tx_frame_sync_pin_oe,
    input  wire logic        int_rx_clock,
    input  wire logic        int_tx_clock,
    input  wire logic        int_tx_data,
    input  wire logic        int_rx_frame_sync,
    input  wire logic        int_tx_frame_sync,
    output logic             rx_data_q,
    output logic             rx_clock_level_q,
    output logic             tx_clock_level_q,
    output logic             rx_frame_start_q,
    output logic             tx_frame_start_q
);
    logic [5:0] pin_control_reg_q;
    logic [1:0] serial_port_ctrl_reg_q;
    logic [5:0] gpio_dir_q;
    logic [5:0] gpio_out_q;
    logic [5:0] pin_async;
    logic [5:0] pin_lvl;
    logic [5:0] pin_rise;
    logic [5:0] pin_fall;
    logic [5:0] gpio_sel;
    logic [5:0] func_oe;
    logic [5:0] func_out;
    logic [5:0] oe_d;
    logic [5:0] out_d;
    logic [1:0] frame_seen_q;
    logic       off_s1_q;
    logic       off_s2_q;
    logic       off_s3_q;
    logic       off_active_q;
    logic       rx_clock_dir_sel;
    logic       tx_clock_dir_sel;
    logic       rx_gpio_enable;
    logic       tx_gpio_enable;
    logic       serial_port_reset;
    sppc_pkg::sppc_pins_out_type pins_q;

    assign rx_clock_dir_sel  = pin_control_reg_q[`SPPC_PINCTL_RX_CLK_DIR];
    assign tx_clock_dir_sel  = pin_control_reg_q[`SPPC_PINCTL_TX_CLK_DIR];
    assign rx_gpio_enable    = pin_control_reg_q[`SPPC_PINCTL_RX_GPIO];
    assign tx_gpio_enable    = pin_control_reg_q[`SPPC_PINCTL_TX_GPIO];
    assign serial_port_reset = !serial_port_ctrl_reg_q[`SPPC_PORTCTL_RUN];

    // one write decode shared by every writable register
    function automatic logic wr_hit(input logic wr, input logic [3:0] addr, input logic [3:0] idx);
        return wr && (addr == idx);
    endfunction

    assign pin_async = {tx_frame_sync_pin_i, rx_frame_sync_pin_i, tx_data_pin_i,
                        rx_data_pin_i, tx_clock_pin_i, rx_clock_pin_i};

    sppc_pin_sync #(
        .WIDTH(`SPPC_NPINS)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .async_in(pin_async),
        .level_q (pin_lvl),
        .rise_q  (pin_rise),
        .fall_q  (pin_fall)
    );

    // emulation off pin is asynchronous; same 3-stage agreement as the serial pins
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            off_s1_q     <= 1'b1;
            off_s2_q     <= 1'b1;
            off_s3_q     <= 1'b1;
            off_active_q <= 1'b0;
        end else begin
            off_s1_q <= emulation_off_pin;
            off_s2_q <= off_s1_q;
            off_s3_q <= off_s2_q;
            if (off_s2_q == off_s3_q) begin
                off_active_q <= !off_s2_q; // RL12
            end
        end
    end

    // register writes
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pin_control_reg_q      <= `SPPC_PINCTL_RESET; // RL1
            serial_port_ctrl_reg_q <= `SPPC_PORTCTL_RESET;
            gpio_dir_q             <= 6'h00;
            gpio_out_q             <= 6'h00;
        end else begin
            if (wr_hit(reg_wr, reg_addr, `SPPC_ADDR_PINCTL)) begin
                pin_control_reg_q <= reg_wdata[5:0];
            end else if (serial_port_reset) begin
                pin_control_reg_q[`SPPC_PINCTL_TX_FS_DIR] <= 1'b0; // RL10
            end
            if (wr_hit(reg_wr, reg_addr, `SPPC_ADDR_PORTCTL)) begin
                serial_port_ctrl_reg_q[`SPPC_PORTCTL_RUN] <= reg_wdata[`SPPC_PORTCTL_RUN];
            end
            serial_port_ctrl_reg_q[`SPPC_PORTCTL_CLK_SAMPLE] <= pin_lvl[`SPPC_PIN_CLKX]; // RL3
            if (wr_hit(reg_wr, reg_addr, `SPPC_ADDR_GPIO_DIR)) begin
                gpio_dir_q <= reg_wdata[5:0];
            end
            if (wr_hit(reg_wr, reg_addr, `SPPC_ADDR_GPIO_OUT)) begin
                gpio_out_q <= reg_wdata[5:0];
            end
        end
    end

    // frame-start sticky flags; a new start wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            frame_seen_q <= 2'h0;
        end else begin
            frame_seen_q <= (frame_seen_q & ~(wr_hit(reg_wr, reg_addr, `SPPC_ADDR_FRAME) ? reg_wdata[1:0] : 2'h0))
                          | {tx_frame_start_q, rx_frame_start_q};
        end
    end

    // register reads, data one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reg_rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `SPPC_ADDR_PINCTL:   reg_rdata_q <= {10'h000, pin_control_reg_q};
                `SPPC_ADDR_PORTCTL:  reg_rdata_q <= {14'h0000, serial_port_ctrl_reg_q}; // RL3
                `SPPC_ADDR_GPIO_DIR: reg_rdata_q <= {10'h000, gpio_dir_q};
                `SPPC_ADDR_GPIO_OUT: reg_rdata_q <= {10'h000, gpio_out_q};
                `SPPC_ADDR_GPIO_IN:  reg_rdata_q <= {10'h000, pin_lvl}; // RL14
                `SPPC_ADDR_FRAME:    reg_rdata_q <= {14'h0000, frame_seen_q};
                default:             reg_rdata_q <= 16'h0000;
            endcase
        end else begin
            reg_rdata_q <= 16'h0000;
        end
    end

    // which pins are handed to general-purpose use
    always_comb begin
        gpio_sel = 6'h00;
        gpio_sel[`SPPC_PIN_CLKR] = rx_gpio_enable; // RL13
        gpio_sel[`SPPC_PIN_DR]   = rx_gpio_enable; // RL5
        gpio_sel[`SPPC_PIN_FSR]  = rx_gpio_enable; // RL8
        gpio_sel[`SPPC_PIN_CLKX] = tx_gpio_enable; // RL4
        gpio_sel[`SPPC_PIN_DX]   = tx_gpio_enable; // RL6
        gpio_sel[`SPPC_PIN_FSX]  = tx_gpio_enable; // RL11
    end

    // serial-function directions and values
    always_comb begin
        func_oe  = 6'h00;
        func_out = 6'h00;
        func_oe[`SPPC_PIN_CLKR]  = rx_clock_dir_sel; // RL1
        func_out[`SPPC_PIN_CLKR] = int_rx_clock;
        func_oe[`SPPC_PIN_CLKX]  = tx_clock_dir_sel; // RL2
        func_out[`SPPC_PIN_CLKX] = int_tx_clock;
        func_oe[`SPPC_PIN_DX]    = 1'b1;
        func_out[`SPPC_PIN_DX]   = int_tx_data;
        func_oe[`SPPC_PIN_FSR]   = pin_control_reg_q[`SPPC_PINCTL_RX_FS_DIR];
        func_out[`SPPC_PIN_FSR]  = int_rx_frame_sync;
        // reset forces the frame sync back to input at once, not only via the stored bit
        func_oe[`SPPC_PIN_FSX]   = pin_control_reg_q[`SPPC_PINCTL_TX_FS_DIR] && !serial_port_reset; // RL10
        func_out[`SPPC_PIN_FSX]  = int_tx_frame_sync;
    end

    always_comb begin
        for (int i = 0; i < `SPPC_NPINS; i++) begin
            oe_d[i]  = gpio_sel[i] ? gpio_dir_q[i] : func_oe[i]; // RL14
            out_d[i] = gpio_sel[i] ? gpio_out_q[i] : func_out[i];
        end
        if (off_active_q) begin
            oe_d = 6'h00; // RL12
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pins_q <= '0;
        end else begin
            pins_q.pin_oe  <= oe_d;
            pins_q.pin_out <= out_d;
        end
    end

    assign rx_clock_pin_o       = pins_q.pin_out[`SPPC_PIN_CLKR];
    assign rx_clock_pin_oe      = pins_q.pin_oe[`SPPC_PIN_CLKR];
    assign tx_clock_pin_o       = pins_q.pin_out[`SPPC_PIN_CLKX];
    assign tx_clock_pin_oe      = pins_q.pin_oe[`SPPC_PIN_CLKX];
    assign rx_data_pin_o        = pins_q.pin_out[`SPPC_PIN_DR];
    assign rx_data_pin_oe       = pins_q.pin_oe[`SPPC_PIN_DR];
    assign tx_data_pin_o        = pins_q.pin_out[`SPPC_PIN_DX];
    assign tx_data_pin_oe       = pins_q.pin_oe[`SPPC_PIN_DX];
    assign rx_frame_sync_pin_o  = pins_q.pin_out[`SPPC_PIN_FSR];
    assign rx_frame_sync_pin_oe = pins_q.pin_oe[`SPPC_PIN_FSR];
    assign tx_frame_sync_pin_o  = pins_q.pin_out[`SPPC_PIN_FSX];
    assign tx_frame_sync_pin_oe = pins_q.pin_oe[`SPPC_PIN_FSX];

    // serial-side view: data sampled on receive clock rise, frame starts on sync rise
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rx_data_q        <= 1'b0;
            rx_clock_level_q <= 1'b0;
            tx_clock_level_q <= 1'b0;
            rx_frame_start_q <= 1'b0;
            tx_frame_start_q <= 1'b0;
        end else begin
            rx_clock_level_q <= pin_lvl[`SPPC_PIN_CLKR];
            tx_clock_level_q <= pin_lvl[`SPPC_PIN_CLKX];
            if (pin_rise[`SPPC_PIN_CLKR] && !rx_gpio_enable) begin
                rx_data_q <= pin_lvl[`SPPC_PIN_DR]; // RL13
            end
            rx_frame_start_q <= pin_rise[`SPPC_PIN_FSR] && !rx_gpio_enable && !serial_port_reset; // RL7
            tx_frame_start_q <= pin_rise[`SPPC_PIN_FSX] && !tx_gpio_enable && !serial_port_reset; // RL9
        end
    end

    property p_off_floats;
        @(posedge clk_sys) disable iff (!rst_b)
        off_active_q |=> (pins_q.pin_oe == 6'h00);
    endproperty
    a_off_floats: assert property (p_off_floats) else $error("pin driven while off"); // RL12

    property p_fsx_reset;
        @(posedge clk_sys) disable iff (!rst_b)
        serial_port_reset |=> !tx_frame_sync_pin_oe;
    endproperty
    a_fsx_reset: assert property (p_fsx_reset) else $error("tx frame sync driven in reset"); // RL10

    property p_clkr_dir;
        @(posedge clk_sys) disable iff (!rst_b)
        (!rx_gpio_enable && !off_active_q) |=> (rx_clock_pin_oe == $past(rx_clock_dir_sel));
    endproperty
    a_clkr_dir: assert property (p_clkr_dir) else $error("rx clock direction wrong"); // RL1

    property p_clkx_dir;
        @(posedge clk_sys) disable iff (!rst_b)
        (!tx_gpio_enable && !off_active_q) |=> (tx_clock_pin_oe == $past(tx_clock_dir_sel));
    endproperty
    a_clkx_dir: assert property (p_clkx_dir) else $error("tx clock direction wrong"); // RL2

    property p_clk_sample;
        @(posedge clk_sys) disable iff (!rst_b)
        reg_rd && reg_addr == `SPPC_ADDR_PORTCTL |=> reg_rdata_q[0] == $past(serial_port_ctrl_reg_q[0]);
    endproperty
    a_clk_sample: assert property (p_clk_sample) else $error("sample bit read wrong"); // RL3

    property p_tx_gpio;
        @(posedge clk_sys) disable iff (!rst_b)
        (tx_gpio_enable && !off_active_q) |=> (tx_data_pin_oe == $past(gpio_dir_q[3]))
            && (tx_clock_pin_o == $past(gpio_out_q[1]));
    endproperty
    a_tx_gpio: assert property (p_tx_gpio) else $error("tx pins not gpio"); // RL4 RL6

    property p_rx_gpio;
        @(posedge clk_sys) disable iff (!rst_b)
        (rx_gpio_enable && !off_active_q) |=> (rx_frame_sync_pin_oe == $past(gpio_dir_q[4]))
            && (rx_clock_pin_oe == $past(gpio_dir_q[0]));
    endproperty
    a_rx_gpio: assert property (p_rx_gpio) else $error("rx pins not gpio"); // RL8 RL13

    property p_rx_frame;
        @(posedge clk_sys) disable iff (!rst_b)
        rx_frame_start_q |-> !$past(rx_gpio_enable) ##1 frame_seen_q[0];
    endproperty
    a_rx_frame: assert property (p_rx_frame) else $error("rx frame start lost"); // RL7

    property p_tx_frame;
        @(posedge clk_sys) disable iff (!rst_b)
        tx_frame_start_q |=> frame_seen_q[1];
    endproperty
    a_tx_frame: assert property (p_tx_frame) else $error("tx frame start lost"); // RL9
endmodule

//--- rtl/sppc_consts.svh
`ifndef SPPC_CONSTS_SVH
`define SPPC_CONSTS_SVH

// register offsets (plain port, word addressed)
`define SPPC_ADDR_PINCTL   4'h0
`define SPPC_ADDR_PORTCTL  4'h1
`define SPPC_ADDR_GPIO_DIR 4'h2
`define SPPC_ADDR_GPIO_OUT 4'h3
`define SPPC_ADDR_GPIO_IN  4'h4
`define SPPC_ADDR_FRAME    4'h5

// pin_control_reg fields
`define SPPC_PINCTL_RX_CLK_DIR  0
`define SPPC_PINCTL_TX_CLK_DIR  1
`define SPPC_PINCTL_RX_FS_DIR   2
`define SPPC_PINCTL_TX_FS_DIR   3
`define SPPC_PINCTL_RX_GPIO     4
`define SPPC_PINCTL_TX_GPIO     5
`define SPPC_PINCTL_RESET       6'h00

// serial_port_ctrl_reg fields
`define SPPC_PORTCTL_CLK_SAMPLE 0
`define SPPC_PORTCTL_RUN        1
`define SPPC_PORTCTL_RESET      2'h0

// pin index in the six-bit pin vectors
`define SPPC_PIN_CLKR      0
`define SPPC_PIN_CLKX      1
`define SPPC_PIN_DR        2
`define SPPC_PIN_DX        3
`define SPPC_PIN_FSR       4
`define SPPC_PIN_FSX       5
`define SPPC_NPINS         6

`endif

//--- rtl/sppc_pkg.sv
package sppc_pkg;

    typedef struct packed {
        logic [5:0] pin_in;
    } sppc_pins_in_type;

    typedef struct packed {
        logic [5:0] pin_out;
        logic [5:0] pin_oe;
    } sppc_pins_out_type;

    typedef struct packed {
        logic rx_frame_start;
        logic tx_frame_start;
        logic rx_clock_edge;
        logic tx_clock_edge;
    } sppc_events_type;

endpackage

//--- rtl/sppc_pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser per pin; a level is accepted once stages two and three agree
module sppc_pin_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_q,
    output logic      [WIDTH-1:0] rise_q,
    output logic      [WIDTH-1:0] fall_q
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    level_q[i] <= 1'b0;
                    rise_q[i]  <= 1'b0;
                    fall_q[i]  <= 1'b0;
                end else begin
                    rise_q[i] <= (s2_q[i] == s3_q[i]) && s2_q[i] && !level_q[i];
                    fall_q[i] <= (s2_q[i] == s3_q[i]) && !s2_q[i] && level_q[i];
                    if (s2_q[i] == s3_q[i]) begin
                        level_q[i] <= s2_q[i];
                    end
                end
            end
        end
    endgenerate
endmodule

//--- bench/sppc_peer.sv
`timescale 1ns/1ps
// external serial peer: sources both frame syncs, both clocks and the data lines
module sppc_peer #(
    parameter int HALF_NS = 200
) (
    input  wire logic       go,
    input  wire logic       slow,
    input  wire logic       idle_lvl,
    input  wire logic [7:0] word,
    output logic      [5:0] pins
);
    logic busy;
    int   h;
    int   i;

    initial begin
        pins = 6'h00;
        busy = 1'b0;
    end

    // clocks stand still outside frames
    always @(*) begin
        if (!busy) begin
            pins[1:0] = {2{idle_lvl}};
        end
    end

    // start off the sampling edge so the synchroniser delay is deterministic
    always @(posedge go) begin
        #10;
        busy = 1'b1;
        h = slow ? 2 * HALF_NS : HALF_NS;
        pins[5:4] = 2'b11;
        for (i = 7; i >= 0; i--) begin
            pins[1:0] = 2'b00;
            pins[2] = word[i];
            pins[3] = ~word[i];
            #h;
            pins[1:0] = 2'b11;
            #h;
            pins[5:4] = 2'b00;
        end
        pins[1:0] = {2{idle_lvl}};
        // released data line shows the inverse so a stale bit cannot pass
        pins[2] = ~word[0];
        pins[3] = word[0];
        busy = 1'b0;
    end
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
`include "sppc_consts.svh"
module tb_top;
    logic        clk_sys, rst_b, reg_wr, reg_rd, emulation_off_pin;
    logic        go, slow, idle_lvl, rd_d, cap_en, cap_bit;
    logic        rx_data_q, rx_clock_level_q, tx_clock_level_q, rx_fs_q, tx_fs_q;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata_q;
    logic [5:0]  pin_i, pin_o, pin_oe, peer_pins;
    logic [4:0]  int_v;
    logic [7:0]  word;
    logic [31:0] seed;
    logic [15:0] expq[$];
    int          failures, comparisons, nrx, ntx, k;

    assign pin_i = (pin_oe & pin_o) | (~pin_oe & peer_pins);

    sppc_top sppc_top_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .emulation_off_pin(emulation_off_pin),
        .rx_clock_pin_i(pin_i[0]), .rx_clock_pin_o(pin_o[0]), .rx_clock_pin_oe(pin_oe[0]),
        .tx_clock_pin_i(pin_i[1]), .tx_clock_pin_o(pin_o[1]), .tx_clock_pin_oe(pin_oe[1]),
        .rx_data_pin_i(pin_i[2]), .rx_data_pin_o(pin_o[2]), .rx_data_pin_oe(pin_oe[2]),
        .tx_data_pin_i(pin_i[3]), .tx_data_pin_o(pin_o[3]), .tx_data_pin_oe(pin_oe[3]),
        .rx_frame_sync_pin_i(pin_i[4]), .rx_frame_sync_pin_o(pin_o[4]),
        .rx_frame_sync_pin_oe(pin_oe[4]),
        .tx_frame_sync_pin_i(pin_i[5]), .tx_frame_sync_pin_o(pin_o[5]),
        .tx_frame_sync_pin_oe(pin_oe[5]),
        .int_rx_clock(int_v[0]), .int_tx_clock(int_v[1]), .int_tx_data(int_v[2]),
        .int_rx_frame_sync(int_v[3]), .int_tx_frame_sync(int_v[4]),
        .rx_data_q(rx_data_q), .rx_clock_level_q(rx_clock_level_q),
        .tx_clock_level_q(tx_clock_level_q), .rx_frame_start_q(rx_fs_q),
        .tx_frame_start_q(tx_fs_q)
    );

    sppc_peer sppc_peer_i (
        .go(go), .slow(slow), .idle_lvl(idle_lvl), .word(word), .pins(peer_pins)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        expq.push_back(e);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask

    // compare drive enables and, where driven, drive values
    task automatic pins(input logic [5:0] oe_e, input logic [5:0] o_e);
        @(negedge clk_sys);
        chk({10'h000, pin_oe}, {10'h000, oe_e});
        chk({10'h000, pin_o & oe_e}, {10'h000, o_e & oe_e});
        @(posedge clk_sys);
    endtask

    task automatic frame(input logic s);
        seed = xs(seed);
        @(posedge clk_sys);
        word <= seed[7:0];
        slow <= s;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (s ? 160 : 90) @(posedge clk_sys);
    endtask

    always @(posedge clk_sys) rd_d <= reg_rd;

    always @(negedge clk_sys) begin
        if (rd_d && expq.size() > 0) begin
            chk(reg_rdata_q, expq.pop_front());
        end
        nrx += rx_fs_q;
        ntx += tx_fs_q;
    end

    always @(posedge pin_i[0]) begin
        if (cap_en) begin
            cap_bit = pin_i[2];
            repeat (6) @(posedge clk_sys);
            chk({15'h0000, rx_data_q}, {15'h0000, cap_bit});
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // whole run is well under a thousand cycles
    initial begin
        #(20000 * 50);
        failures++;
        tally_and_finish();
    end

    initial begin
        {rst_b, reg_wr, reg_rd, go, slow, idle_lvl, cap_en} = 7'h00;
        emulation_off_pin = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        int_v = 5'h00;
        word = 8'h00;
        seed = 32'h0000_9e6e;
        {failures, comparisons, nrx, ntx} = 0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk_sys);
        pins(6'b001000, 6'b000000);
        rd(`SPPC_ADDR_PINCTL, 16'h0000);
        rd(`SPPC_ADDR_PORTCTL, 16'h0000);
        wr(4'hf, 16'hffff);
        rd(4'hf, 16'h0000);
        idle_lvl <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rd(`SPPC_ADDR_PORTCTL, 16'h0001);
        @(negedge clk_sys);
        chk({15'h0000, tx_clock_level_q}, 16'h0001);
        chk({15'h0000, rx_clock_level_q}, 16'h0001);
        wr(`SPPC_ADDR_PORTCTL, 16'h0002);
        wr(`SPPC_ADDR_PINCTL, 16'h000f);
        for (k = 0; k < 3; k++) begin
            seed = xs(seed);
            int_v <= seed[4:0];
            repeat (3) @(posedge clk_sys);
            pins(6'b111011, {int_v[4:2], 1'b0, int_v[1:0]});
        end
        rd(`SPPC_ADDR_PINCTL, 16'h000f);
        emulation_off_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        pins(6'b000000, 6'b000000);
        emulation_off_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        pins(6'b111011, {int_v[4:2], 1'b0, int_v[1:0]});
        wr(`SPPC_ADDR_PORTCTL, 16'h0000);
        repeat (2) @(posedge clk_sys);
        pins(6'b011011, {int_v[4:2], 1'b0, int_v[1:0]});
        rd(`SPPC_ADDR_PINCTL, 16'h0007);
        // frames from the peer, fast then slow
        wr(`SPPC_ADDR_PINCTL, 16'h0000);
        wr(`SPPC_ADDR_PORTCTL, 16'h0002);
        idle_lvl <= 1'b0;
        repeat (8) @(posedge clk_sys);
        wr(`SPPC_ADDR_FRAME, 16'h0003);
        nrx = 0;
        ntx = 0;
        cap_en <= 1'b1;
        frame(1'b0);
        frame(1'b1);
        cap_en <= 1'b0;
        chk(16'(nrx), 16'h0002);
        chk(16'(ntx), 16'h0002);
        rd(`SPPC_ADDR_FRAME, 16'h0003);
        wr(`SPPC_ADDR_FRAME, 16'h0003);
        rd(`SPPC_ADDR_FRAME, 16'h0000);
        wr(`SPPC_ADDR_PORTCTL, 16'h0000);
        frame(1'b0);
        rd(`SPPC_ADDR_FRAME, 16'h0000);
        wr(`SPPC_ADDR_PORTCTL, 16'h0002);
        wr(`SPPC_ADDR_PINCTL, 16'h0030);
        frame(1'b0);
        rd(`SPPC_ADDR_FRAME, 16'h0000);
        chk(16'(nrx + ntx), 16'h0004);
        // gpio mode overrides the direction bits
        for (k = 0; k < 4; k++) begin
            seed = xs(seed);
            wr(`SPPC_ADDR_PINCTL, {10'h000, 2'b11, seed[3:0]});
            wr(`SPPC_ADDR_GPIO_DIR, {10'h000, seed[9:4]});
            wr(`SPPC_ADDR_GPIO_OUT, {10'h000, seed[15:10]});
            repeat (2) @(posedge clk_sys);
            pins(seed[9:4], seed[15:10]);
            wr(`SPPC_ADDR_GPIO_IN, 16'hffff);
            repeat (6) @(posedge clk_sys);
            rd(`SPPC_ADDR_GPIO_IN, {10'h000, (seed[9:4] & seed[15:10]) | (~seed[9:4] & peer_pins)});
        end
        repeat (4) @(posedge clk_sys);
        tally_and_finish();
    end
endmodule
